// file: core/ssdr_pkg.sv
// Package of constants for the serial status and data register block
// What this block does
// - Transfer-complete flag sets at each byte end; interrupt when enabled.
// - Transfer-complete clears after status access then data read or write.
// - Data writes ignored while transfer-complete set until status read.
// - Write-collision flag sets on data write during a transmission.
// - Overrun sets when new byte arrives while transfer-complete still set.
// - Overrun clears when software reads the status register.
// - Enabled master mode with internal select low sets mode-fault flag.
// - Mode fault clears after status access while set, then control write.
// - Output-disable stops the data output; otherwise output follows enable, and select in slave mode.
// - Select management picks pin or software select bit as internal select.
// - Software select bit zero selects, one deselects.
// - In master mode an accepted data write starts one byte exchange.
// - Received byte copied to read buffer at completion; reads return it.
// - Data write loads the transmit shift register directly.
// - Control/status register resets to zero; data undefined.
// - One interrupt while enable set and any of three flags set.
// - Mode fault clears peripheral enable and master select.
package ssdr_pkg;
	// ----------------------------------------
	// Register offsets (byte addresses = 4 * index)
	// ----------------------------------------
	localparam logic [7:0] SSDR_IDX_DATA = 8'h21;
	localparam logic [7:0] SSDR_IDX_CTRL = 8'h22;
	localparam logic [7:0] SSDR_IDX_CSR = 8'h23;
	localparam logic [7:0] SSDR_IDX_IRQ_STAT = 8'h24;
	localparam logic [7:0] SSDR_IDX_IRQ_CLR = 8'h25;
	localparam logic [7:0] SSDR_IDX_IRQ_EN = 8'h26;
	localparam logic [9:0] SSDR_ADDR_W = 10'h00a;
	// ----------------------------------------
	// Control bits
	// ----------------------------------------
	localparam int SSDR_CR_IRQ_EN = 7;
	localparam int SSDR_CR_PERIPH_EN = 6;
	localparam int SSDR_CR_MASTER = 4;
	localparam int SSDR_CR_CPOL = 3;
	localparam int SSDR_CR_CPHA = 2;
	// ----------------------------------------
	// Control/status bits
	// ----------------------------------------
	localparam int SSDR_CS_DONE = 7;
	localparam int SSDR_CS_WRITE_COLLISION_FLAG = 6;
	localparam int SSDR_CS_OVR = 5;
	localparam int SSDR_CS_MODE_FAULT_FLAG = 4;
	localparam int SSDR_CS_OUT_DIS = 2;
	localparam int SSDR_CS_SW_MANAGE = 1;
	localparam int SSDR_CS_SW_LEVEL = 0;
	localparam logic [7:0] SSDR_CS_RW_MASK = 8'h07;
	localparam logic [7:0] SSDR_CTRL_RESET = 8'h00;
	localparam logic [7:0] SSDR_CSR_RESET = 8'h00;
	// ----------------------------------------
	// Interrupt status bits: done, overrun, mode fault, collision
	// ----------------------------------------
	localparam int SSDR_EV_W = 4;
	localparam logic [3:0] SSDR_EV_RESET = 4'h0;
	// ----------------------------------------
	// Master clock: half period in system cycles
	// ----------------------------------------
	localparam logic [3:0] SSDR_SCK_HALF = 4'h4;
	localparam logic [3:0] SSDR_BITS = 4'h8;
endpackage

// file: core/ssdr_shifter.sv
// Byte shift engine, master and slave, mode 0/1 via phase bit
`timescale 1ns/1ns
module ssdr_shifter
	import ssdr_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// Control
	input wire logic master_i,
	input wire logic enable_i,
	input wire logic cpol_i,
	input wire logic cpha_i,
	input wire logic select_n_i,
	input wire logic load_i,
	input wire logic [7:0] load_data_i,
	// Synchronised link
	input wire logic sck_i,
	input wire logic sdi_i,
	// Outputs
	output logic sck_o,
	output logic sdo_o,
	output logic busy_o,
	output logic done_o,
	output logic [7:0] rx_o
);
	logic [7:0] sh_q;
	logic [3:0] cnt_q;
	logic [3:0] div_q;
	logic sck_prev_q;
	logic lead;
	logic trail;
	logic ph;
	logic tick;

	// ----------------------------------------
	// Edge sources
	// ----------------------------------------
	assign tick = master_i && busy_o && (div_q == SSDR_SCK_HALF - 4'h1);
	assign ph = master_i ? (sck_o ^ cpol_i) : (sck_prev_q ^ cpol_i);
	always_comb begin
		lead = 1'b0;
		trail = 1'b0;
		if (master_i) begin
			lead = tick && !(sck_o ^ cpol_i);
			trail = tick && (sck_o ^ cpol_i);
		end else if (!select_n_i && (sck_i != sck_prev_q)) begin
			lead = !ph;
			trail = ph;
		end
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			sck_prev_q <= 1'b0;
		end else begin
			sck_prev_q <= sck_i;
		end
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			div_q <= 4'h0;
		end else if (!busy_o || tick) begin
			div_q <= 4'h0;
		end else begin
			div_q <= div_q + 4'h1;
		end
	end

	// ----------------------------------------
	// Shift and count; sample on first or second edge by phase
	// ----------------------------------------
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			sh_q <= 8'h00;
			cnt_q <= 4'h0;
			busy_o <= 1'b0;
			done_o <= 1'b0;
			sck_o <= 1'b0;
			sdo_o <= 1'b0;
		end else begin
			done_o <= 1'b0;
			if (!enable_i) begin
				busy_o <= 1'b0;
				cnt_q <= 4'h0;
				sck_o <= cpol_i;
			end else if (load_i) begin
				sh_q <= load_data_i;
				busy_o <= master_i;
				cnt_q <= 4'h0;
				sck_o <= cpol_i;
				if (!cpha_i) begin
					sdo_o <= load_data_i[7];
				end
			end else begin
				if (master_i && tick) begin
					sck_o <= !sck_o;
				end
				if (!master_i && select_n_i) begin
					cnt_q <= 4'h0;
				end
				if ((lead && cpha_i) || (trail && !cpha_i)) begin
					sdo_o <= sh_q[7];
				end
				if ((lead && !cpha_i) || (trail && cpha_i)) begin
					sh_q <= {sh_q[6:0], sdi_i};
					if ((cnt_q == SSDR_BITS - 4'h1) && !(master_i && !cpha_i)) begin
						cnt_q <= 4'h0;
						done_o <= 1'b1;
						busy_o <= 1'b0;
					end else begin
						cnt_q <= cnt_q + 4'h1;
						if (!master_i) begin
							busy_o <= 1'b1;
						end
					end
				end
				// Phase 0 master ends on the last trailing edge, so the clock idles
				if (master_i && !cpha_i && trail && (cnt_q == SSDR_BITS)) begin
					cnt_q <= 4'h0;
					done_o <= 1'b1;
					busy_o <= 1'b0;
				end
			end
		end
	end

	assign rx_o = sh_q;
endmodule

// file: core/ssdr_top.sv
// Serial status, control and data registers with Avalon-MM slave
//
// Decided for this implementation: register access over Avalon-MM.
`timescale 1ns/1ns
module ssdr_top
	import ssdr_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// Avalon-MM slave
	input wire logic [9:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	// Interrupt
	output logic irq_o,
	// Serial link
	input wire logic sck_i,
	output logic sck_o,
	output logic sck_oe_o,
	input wire logic sdi_i,
	output logic sdo_o,
	output logic sdo_oe_o,
	input wire logic select_n_i,
	// Select pin released for general use
	output logic select_pin_free_o
);
	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [7:0] ctrl_q;
	logic [7:0] csr_q;
	logic [7:0] rx_buf_q;
	logic [3:0] ev_q;
	logic [3:0] ev_en_q;
	logic csr_seen_q;
	logic mode_fault_flag_seen_q;
	logic wr_gate_q;
	logic ack_q;
	logic [1:0] sck_s_q;
	logic [1:0] sdi_s_q;
	logic [1:0] sel_s_q;
	logic [7:0] idx;
	logic acc;
	logic rd;
	logic wr;
	logic data_rd;
	logic data_wr;
	logic data_wr_ok;
	logic csr_rd;
	logic ctrl_wr;
	logic csr_wr;
	logic int_sel_n;
	logic mode_fault_flag_ev;
	logic busy;
	logic done;
	logic sh_sck;
	logic sh_sdo;
	logic [7:0] rx;
	logic [3:0] ev_set;
	logic irq_d;

	function automatic logic hit(input logic [9:0] a, input logic [7:0] i);
		hit = (a[9:2] == i) && (a[1:0] == 2'b00);
	endfunction

	// ----------------------------------------
	// Bus decode: one wait cycle, answer on the second edge
	// ----------------------------------------
	assign acc = (avs_read_i || avs_write_i) && !ack_q;
	assign rd = avs_read_i && !ack_q;
	assign wr = avs_write_i && !ack_q && avs_byteenable_i[0];
	assign idx = avs_address_i[9:2];
	assign data_rd = rd && hit(avs_address_i, SSDR_IDX_DATA);
	assign data_wr = wr && hit(avs_address_i, SSDR_IDX_DATA);
	assign csr_rd = rd && hit(avs_address_i, SSDR_IDX_CSR);
	assign csr_wr = wr && hit(avs_address_i, SSDR_IDX_CSR);
	assign ctrl_wr = wr && hit(avs_address_i, SSDR_IDX_CTRL);
	assign data_wr_ok = data_wr && !wr_gate_q;

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
			avs_waitrequest_o <= 1'b1;
		end else begin
			ack_q <= acc;
			// Own flop so the output comes straight from a register
			avs_waitrequest_o <= !acc;
		end
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			avs_readdata_o <= 32'h0000_0000;
		end else if (rd) begin
			avs_readdata_o <= 32'h0000_0000;
			case (idx)
				SSDR_IDX_DATA: avs_readdata_o[7:0] <= rx_buf_q;
				SSDR_IDX_CTRL: avs_readdata_o[7:0] <= ctrl_q;
				SSDR_IDX_CSR: avs_readdata_o[7:0] <= csr_q & 8'hf7;
				SSDR_IDX_IRQ_STAT: avs_readdata_o[3:0] <= ev_q;
				SSDR_IDX_IRQ_EN: avs_readdata_o[3:0] <= ev_en_q;
				default: avs_readdata_o <= 32'h0000_0000;
			endcase
		end
	end

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			sck_s_q <= 2'h0;
			sdi_s_q <= 2'h0;
			sel_s_q <= 2'h3;
		end else begin
			sck_s_q <= {sck_s_q[0], sck_i};
			sdi_s_q <= {sdi_s_q[0], sdi_i};
			sel_s_q <= {sel_s_q[0], select_n_i};
		end
	end

	// Internal select from pin or software level
	assign int_sel_n = csr_q[SSDR_CS_SW_MANAGE] ? csr_q[SSDR_CS_SW_LEVEL] : sel_s_q[1];
	assign mode_fault_flag_ev = ctrl_q[SSDR_CR_MASTER] && ctrl_q[SSDR_CR_PERIPH_EN] && !int_sel_n;

	// ----------------------------------------
	// Control register
	// ----------------------------------------
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			ctrl_q <= SSDR_CTRL_RESET;
		end else if (mode_fault_flag_ev) begin
			ctrl_q[SSDR_CR_PERIPH_EN] <= 1'b0;
			ctrl_q[SSDR_CR_MASTER] <= 1'b0;
		end else if (ctrl_wr) begin
			ctrl_q <= avs_writedata_i[7:0];
		end
	end

	// ----------------------------------------
	// Status sequence tracking
	// ----------------------------------------
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			csr_seen_q <= 1'b0;
			mode_fault_flag_seen_q <= 1'b0;
			wr_gate_q <= 1'b0;
		end else begin
			if (csr_rd || csr_wr) begin
				csr_seen_q <= 1'b1;
				mode_fault_flag_seen_q <= csr_q[SSDR_CS_MODE_FAULT_FLAG];
			end else begin
				if (data_rd || data_wr) begin
					csr_seen_q <= 1'b0;
				end
				if (ctrl_wr) begin
					mode_fault_flag_seen_q <= 1'b0;
				end
			end
			// Gate opens only on a status read after the flag set
			if (done) begin
				wr_gate_q <= 1'b1;
			end else if (csr_rd) begin
				wr_gate_q <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Control/status register; set wins over clear
	// ----------------------------------------
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			csr_q <= SSDR_CSR_RESET;
		end else begin
			if (csr_wr) begin
				csr_q[2:0] <= avs_writedata_i[2:0] & SSDR_CS_RW_MASK[2:0];
			end
			if (done) begin
				csr_q[SSDR_CS_DONE] <= 1'b1;
			end else if (csr_seen_q && (data_rd || data_wr)) begin
				csr_q[SSDR_CS_DONE] <= 1'b0;
			end
			if (data_wr && busy) begin
				csr_q[SSDR_CS_WRITE_COLLISION_FLAG] <= 1'b1;
			end else if (csr_seen_q && (data_rd || data_wr)) begin
				csr_q[SSDR_CS_WRITE_COLLISION_FLAG] <= 1'b0;
			end
			if (done && csr_q[SSDR_CS_DONE]) begin
				csr_q[SSDR_CS_OVR] <= 1'b1;
			end else if (csr_rd) begin
				csr_q[SSDR_CS_OVR] <= 1'b0;
			end
			if (mode_fault_flag_ev) begin
				csr_q[SSDR_CS_MODE_FAULT_FLAG] <= 1'b1;
			end else if (mode_fault_flag_seen_q && ctrl_wr) begin
				csr_q[SSDR_CS_MODE_FAULT_FLAG] <= 1'b0;
			end
		end
	end

	// Buffer only updated at completion, never live
	always_ff @(posedge clk_sys_i) begin
		if (done) begin
			rx_buf_q <= rx;
		end
	end

	// ----------------------------------------
	// Shift engine
	// ----------------------------------------
	ssdr_shifter u_shift (
		.clk_sys_i(clk_sys_i),
		.rst_i(rst_i),
		.master_i(ctrl_q[SSDR_CR_MASTER]),
		.enable_i(ctrl_q[SSDR_CR_PERIPH_EN]),
		.cpol_i(ctrl_q[SSDR_CR_CPOL]),
		.cpha_i(ctrl_q[SSDR_CR_CPHA]),
		.select_n_i(int_sel_n),
		.load_i(data_wr_ok && !busy),
		.load_data_i(avs_writedata_i[7:0]),
		.sck_i(sck_s_q[1]),
		.sdi_i(sdi_s_q[1]),
		.sck_o(sh_sck),
		.sdo_o(sh_sdo),
		.busy_o(busy),
		.done_o(done),
		.rx_o(rx)
	);

	// ----------------------------------------
	// Pin drivers, registered
	// ----------------------------------------
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			sck_o <= 1'b0;
			sck_oe_o <= 1'b0;
			sdo_o <= 1'b0;
			sdo_oe_o <= 1'b0;
			select_pin_free_o <= 1'b0;
		end else begin
			sck_o <= sh_sck;
			sck_oe_o <= ctrl_q[SSDR_CR_PERIPH_EN] && ctrl_q[SSDR_CR_MASTER];
			sdo_o <= sh_sdo;
			// Slave drives only while selected to share the line
			sdo_oe_o <= ctrl_q[SSDR_CR_PERIPH_EN] && !csr_q[SSDR_CS_OUT_DIS]
				&& (ctrl_q[SSDR_CR_MASTER] || !int_sel_n);
			select_pin_free_o <= csr_q[SSDR_CS_SW_MANAGE];
		end
	end

	// ----------------------------------------
	// Interrupt: sticky events, enable, write-one clear
	// ----------------------------------------
	assign ev_set = {data_wr && busy, mode_fault_flag_ev, done && csr_q[SSDR_CS_DONE], done};
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			ev_q <= SSDR_EV_RESET;
			ev_en_q <= SSDR_EV_RESET;
		end else begin
			ev_q <= ev_set | (ev_q & ~((wr && hit(avs_address_i, SSDR_IDX_IRQ_CLR))
				? avs_writedata_i[3:0] : 4'h0));
			if (wr && hit(avs_address_i, SSDR_IDX_IRQ_EN)) begin
				ev_en_q <= avs_writedata_i[3:0];
			end
		end
	end

	// Flag-level request plus sticky-event request
	assign irq_d = (ctrl_q[SSDR_CR_IRQ_EN] && (csr_q[SSDR_CS_DONE] || csr_q[SSDR_CS_OVR]
		|| csr_q[SSDR_CS_MODE_FAULT_FLAG])) || |(ev_q & ev_en_q);
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= irq_d;
		end
	end
endmodule

// file: sim/ssdr_asserts.sv
// Port assertions for the serial register block
`timescale 1ns/1ns
module ssdr_asserts
	import ssdr_pkg::*;
(
	// Watched ports
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic [9:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	input wire logic [31:0] avs_readdata_o,
	input wire logic avs_waitrequest_o,
	input wire logic irq_o,
	input wire logic select_n_i,
	input wire logic sck_oe_o,
	input wire logic sdo_oe_o,
	input wire logic select_pin_free_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	// ----------------------------------------
	// Shadows of written register bits
	// ----------------------------------------
	logic wr;
	logic od_q, sm_q, ie_q, en_q;
	assign wr = avs_write_i && avs_waitrequest_o && avs_byteenable_i[0];
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			od_q <= 1'b0;
			sm_q <= 1'b0;
		end else if (wr && avs_address_i[9:2] == SSDR_IDX_CSR) begin
			od_q <= avs_writedata_i[SSDR_CS_OUT_DIS];
			sm_q <= avs_writedata_i[SSDR_CS_SW_MANAGE];
		end
	end
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			ie_q <= 1'b0;
			en_q <= 1'b0;
		end else if (wr && avs_address_i[9:2] == SSDR_IDX_CTRL) begin
			ie_q <= avs_writedata_i[SSDR_CR_IRQ_EN];
		end else if (wr && avs_address_i[9:2] == SSDR_IDX_IRQ_EN) begin
			en_q <= |avs_writedata_i[3:0];
		end
	end
	sequence s_req;
		(avs_read_i || avs_write_i) && avs_waitrequest_o;
	endsequence
	sequence s_rd(logic [7:0] idx);
		avs_read_i && avs_waitrequest_o && avs_address_i[9:2] == idx;
	endsequence
	// ----------------------------------------
	// Checks
	// ----------------------------------------
	chk_one_wait: assert property (s_req |=> !avs_waitrequest_o)
		else $error("request not answered after one wait cycle");
	chk_read_stands: assert property (!avs_read_i |=> $stable(avs_readdata_o))
		else $error("read data moved without a read");
	chk_bit3_zero: assert property (
		s_rd(SSDR_IDX_CSR) |=> avs_readdata_o[3] == 1'b0 && avs_readdata_o[31:8] == 24'h0)
		else $error("status reserved bit read as one");
	chk_unmapped_zero: assert property (s_rd(8'h3f) |=> avs_readdata_o == 32'h0)
		else $error("unmapped read not zero");
	chk_out_off: assert property (od_q [*3] |-> !sdo_oe_o)
		else $error("data output driven while disabled");
	chk_pin_free: assert property ($stable(sm_q) [*3] |-> select_pin_free_o == sm_q)
		else $error("select pin release wrong");
	chk_fault_drop: assert property (
		(sck_oe_o && !select_n_i && !sm_q) [*3] |-> ##[1:6] !sck_oe_o)
		else $error("master kept driving after select fault");
	chk_irq_quiet: assert property ((!ie_q && !en_q) [*3] |-> !irq_o)
		else $error("interrupt raised with all enables off");
endmodule

bind ssdr_top ssdr_asserts i_ssdr_asserts (.clk_sys_i, .rst_i, .avs_address_i, .avs_read_i,
	.avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o,
	.irq_o, .select_n_i, .sck_oe_o, .sdo_oe_o, .select_pin_free_o);

// file: sim/ssdr_slave_model.sv
// Serial slave model facing the block in master mode
`timescale 1ns/1ns
module ssdr_slave_model (
	// Link
	input wire logic sck_i,
	input wire logic oe_i,
	input wire logic data_i,
	output logic data_o,
	// Bench side
	input wire logic load_i,
	input wire logic [7:0] reply_i,
	output logic [7:0] got_o
);
	logic [7:0] tx_q;
	initial got_o = 8'h00;
	// Idle line shows the inverse, so a stale bit never passes
	assign data_o = oe_i ? tx_q[7] : ~tx_q[7];
	always @(posedge sck_i) got_o <= {got_o[6:0], data_i};
	always @(negedge sck_i or posedge load_i) begin
		if (load_i) tx_q <= reply_i;
		else tx_q <= {tx_q[6:0], 1'b0};
	end
endmodule

// file: sim/testbench.sv
// Self-checking bench for the serial register block
`timescale 1ns/1ns
module testbench;
	import ssdr_pkg::*;
	logic clk_sys_i, rst_i, avs_read_i, avs_write_i, avs_waitrequest_o, irq_o;
	logic [9:0] avs_address_i;
	logic [31:0] avs_writedata_i, avs_readdata_o;
	logic [3:0] avs_byteenable_i;
	logic sck_i, sck_o, sck_oe_o, sdi_i, sdo_o, sdo_oe_o, select_n_i, select_pin_free_o;
	logic m_sdi, m_load, sdi_b;
	logic [7:0] m_got, q, s_out;
	int errors, num_checks;
	assign sdi_i = sck_oe_o ? m_sdi : sdi_b;
	ssdr_top i_ssdr_top (.clk_sys_i, .rst_i, .avs_address_i, .avs_read_i, .avs_write_i,
		.avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .irq_o,
		.sck_i, .sck_o, .sck_oe_o, .sdi_i, .sdo_o, .sdo_oe_o, .select_n_i, .select_pin_free_o);
	ssdr_slave_model i_ssdr_slave_model (.sck_i(sck_o), .oe_i(sck_oe_o), .data_i(sdo_o),
		.data_o(m_sdi), .load_i(m_load), .reply_i(8'h3c), .got_o(m_got));
	initial begin
		clk_sys_i = 1'b0;
		forever #10 clk_sys_i = ~clk_sys_i;
	end
	task automatic results;
		$display("checks %0d mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk1(input logic got, input logic exp);
		chk8({7'h0, got}, {7'h0, exp});
	endtask
	// Holds the request until waitrequest is seen low at a rising edge
	task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] d);
		int n;
		logic ws;
		@(posedge clk_sys_i);
		avs_address_i <= a;
		avs_writedata_i <= {24'h0, d};
		avs_write_i <= w;
		avs_read_i <= ~w;
		n = 0;
		do begin
			@(posedge clk_sys_i);
			ws = avs_waitrequest_o;
			n++;
		end while (ws !== 1'b0 && n < 50);
		q = avs_readdata_o[7:0];
		avs_write_i <= 1'b0;
		avs_read_i <= 1'b0;
		if (ws !== 1'b0) begin
			errors++;
			results;
		end
	endtask
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rd(input logic [9:0] a, input logic [7:0] exp);
		bus(1'b0, a, 8'h00);
		chk8(q, exp);
	endtask
	task automatic poll(input logic [7:0] m);
		int n;
		n = 0;
		do begin
			bus(1'b0, 10'h090, 8'h00);
			n++;
		end while ((q & m) == 8'h00 && n < 400);
		if ((q & m) == 8'h00) begin
			errors++;
			results;
		end
	endtask
	task automatic st;
		repeat (3) @(negedge clk_sys_i);
	endtask
	// Link clock stands still outside the frame
	task automatic sbyte(input logic [7:0] b, input logic p);
		for (int i = 7; i >= 0; i--) begin
			sdi_b <= b[i];
			repeat (4) @(posedge clk_sys_i);
			sck_i <= ~p;
			repeat (4) @(posedge clk_sys_i);
			s_out[i] = sdo_o;
			sck_i <= p;
		end
		sdi_b <= ~b[0];
	endtask
	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		errors = 0;
		num_checks = 0;
		rst_i = 1'b1;
		avs_read_i = 1'b0;
		avs_write_i = 1'b0;
		avs_address_i = 10'h000;
		avs_writedata_i = 32'h0;
		avs_byteenable_i = 4'h1;
		sck_i = 1'b0;
		sdi_b = 1'b0;
		select_n_i = 1'b1;
		m_load = 1'b0;
		repeat (2) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		rd(10'h08c, 8'h00);
		rd(10'h090, 8'h00);
		rd(10'h088, 8'h00);
		rd(10'h0fc, 8'h00);
		$display("test reset done");
		wr(10'h08c, 8'hf7);
		rd(10'h08c, 8'h07);
		st;
		chk1(select_pin_free_o, 1'b1);
		wr(10'h088, 8'h50);
		st;
		chk1(sdo_oe_o, 1'b0);
		wr(10'h08c, 8'h03);
		st;
		chk1(sdo_oe_o, 1'b1);
		$display("test output control done");
		wr(10'h088, 8'hd0);
		m_load <= 1'b1;
		wr(10'h084, 8'ha5);
		m_load <= 1'b0;
		wr(10'h084, 8'h11);
		poll(8'h01);
		st;
		chk1(irq_o, 1'b1);
		chk8(m_got, 8'ha5);
		wr(10'h084, 8'h77);
		rd(10'h08c, 8'hc3);
		rd(10'h084, 8'h3c);
		rd(10'h08c, 8'h03);
		chk8(m_got, 8'ha5);
		rd(10'h090, 8'h09);
		wr(10'h094, 8'h0f);
		st;
		chk1(irq_o, 1'b0);
		$display("test master done");
		wr(10'h088, 8'hc0);
		wr(10'h08c, 8'h00);
		wr(10'h084, 8'hc3);
		select_n_i <= 1'b0;
		repeat (8) @(posedge clk_sys_i);
		sbyte(8'h96, 1'b0);
		poll(8'h01);
		chk8(s_out, 8'hc3);
		rd(10'h084, 8'h96);
		sbyte(8'h69, 1'b0);
		poll(8'h02);
		rd(10'h08c, 8'ha0);
		rd(10'h08c, 8'h80);
		select_n_i <= 1'b1;
		bus(1'b0, 10'h084, 8'h00);
		rd(10'h08c, 8'h00);
		// Idle-high link clock in slave mode
		sck_i <= 1'b1;
		wr(10'h088, 8'hc8);
		wr(10'h084, 8'h5a);
		select_n_i <= 1'b0;
		repeat (8) @(posedge clk_sys_i);
		sbyte(8'ha6, 1'b1);
		poll(8'h01);
		chk8(s_out, 8'h5a);
		rd(10'h08c, 8'h80);
		rd(10'h084, 8'ha6);
		select_n_i <= 1'b1;
		rd(10'h08c, 8'h00);
		wr(10'h094, 8'h0f);
		$display("test slave done");
		wr(10'h088, 8'hd0);
		select_n_i <= 1'b0;
		poll(8'h04);
		st;
		chk1(irq_o, 1'b1);
		chk1(sck_oe_o, 1'b0);
		select_n_i <= 1'b1;
		rd(10'h088, 8'h80);
		wr(10'h088, 8'h80);
		rd(10'h08c, 8'h10);
		wr(10'h088, 8'h80);
		rd(10'h08c, 8'h00);
		$display("test mode fault done");
		wr(10'h088, 8'h00);
		wr(10'h098, 8'h04);
		st;
		chk1(irq_o, 1'b1);
		wr(10'h098, 8'h00);
		st;
		chk1(irq_o, 1'b0);
		wr(10'h098, 8'h04);
		wr(10'h094, 8'h04);
		rd(10'h090, 8'h00);
		st;
		chk1(irq_o, 1'b0);
		$display("test interrupts done");
		results;
	end
endmodule
